// ---- inc/gdm_pkg.sv ----
// package for the gpio drive mode select block: register map, codes and carriers
package gdm_pkg;

  localparam int NUM_PORTS_DEF = 5;
  localparam int PORT_WIDTH    = 8;
  localparam int ADDR_WIDTH    = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_P0_LOW  = 6'h00;
  localparam logic [5:0] IDX_P0_HIGH = 6'h01;
  localparam logic [5:0] IDX_P1_LOW  = 6'h04;
  localparam logic [5:0] IDX_P1_HIGH = 6'h05;
  localparam logic [5:0] IDX_P2_LOW  = 6'h08;
  localparam logic [5:0] IDX_P2_HIGH = 6'h09;
  localparam logic [5:0] IDX_P3_LOW  = 6'h0c;
  localparam logic [5:0] IDX_P3_HIGH = 6'h0d;
  localparam logic [5:0] IDX_P4_LOW  = 6'h10;
  localparam logic [5:0] IDX_P4_HIGH = 6'h11;
  localparam int         IDX_LSB     = 2;

  // reset values and field positions
  localparam logic [7:0] LOW_RESET      = 8'h00;
  localparam logic [7:0] HIGH_RESET     = 8'hff;
  localparam int         CODE_LOW_POS   = 0;
  localparam int         CODE_HIGH_POS  = 1;
  localparam int         STALE_MSB      = 7;
  localparam int         STALE_LSB      = 4;
  localparam int         STALE_PORT     = 4;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_DECODEERR = 2'b11;

  typedef enum logic [1:0] {
    DRIVE_RES_HIGH  = 2'b00,
    DRIVE_STRONG    = 2'b01,
    DRIVE_HIGHZ     = 2'b10,
    DRIVE_OPEN_LOW  = 2'b11
  } gdm_code_type;

  // per-pin pad control
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic input_en;
  } gdm_pad_type;

  // avalon request as the slave sees it
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] address;
    logic                  read;
    logic                  write;
    logic [3:0]            byteenable;
    logic [31:0]           writedata;
  } gdm_req_type;

endpackage

// ---- logic/gdm_drive_select.sv ----
// gpio drive mode select: two drive-bit registers per port over avalon-mm, per-pin pad control
// Contract
// (R1) each pin's two-bit drive code pairs the same bit position of its port's low and high registers.
// (R2) the low drive register supplies bit 0 of every pin code of its port.
// (R3) the high drive register supplies bit 1 of every pin code of its port.
// (R4) code 00 drives high resistively and low strongly, code 01 drives both levels strongly.
// (R5) code 10 floats the pin and disables its input, and reset leaves high registers at ff and low at 00.
// (R6) code 11 floats on a high output and drives strongly on a low output, an open-drain mode.
// (R7) software using an open-drain pin as input keeps its output value bit high.
// (R8) a read of either port 4 drive register returns the last bus value in bits 7 to 4.
// (R9) software masks off the upper four bits of a port 4 drive register read.
// (R10) a write changes pin drive from the cycle after the write completes with no further action.
// (R11) drive registers of ports 0 to 3 read back all eight stored bits.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module gdm_drive_select
  import gdm_pkg::*;
#(
  parameter int NUM_PORTS = NUM_PORTS_DEF
) (
  // clock and reset
  input  wire logic                              clk_in,
  input  wire logic                              reset_in,
  // avalon-mm slave
  input  wire logic [ADDR_WIDTH-1:0]             avs_address_in,
  input  wire logic                              avs_read_in,
  input  wire logic                              avs_write_in,
  input  wire logic [3:0]                        avs_byteenable_in,
  input  wire logic [31:0]                       avs_writedata_in,
  output logic      [31:0]                       avs_readdata_out,
  output logic      [1:0]                        avs_response_out,
  output logic                                   avs_waitrequest_out,
  // port side
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   port_output_value_in,
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_level_in,
  output logic      [NUM_PORTS*PORT_WIDTH-1:0]   pin_input_out,
  output gdm_pad_type [NUM_PORTS*PORT_WIDTH-1:0] pad_ctl_out
);

  localparam int NUM_PINS = NUM_PORTS * PORT_WIDTH;

  gdm_req_type req;
  assign req.address    = avs_address_in;
  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.byteenable = avs_byteenable_in;
  assign req.writedata  = avs_writedata_in;

  logic [PORT_WIDTH-1:0] drive_low_reg  [NUM_PORTS];
  logic [PORT_WIDTH-1:0] drive_low_next [NUM_PORTS];
  logic [PORT_WIDTH-1:0] drive_high_reg [NUM_PORTS];
  logic [PORT_WIDTH-1:0] drive_high_next[NUM_PORTS];
  logic                  ack_reg;
  logic                  ack_next;
  logic [31:0]           rdata_reg;
  logic [31:0]           rdata_next;
  logic [1:0]            resp_reg;
  logic [1:0]            resp_next;
  logic [7:0]            last_bus_reg;
  logic [7:0]            last_bus_next;

  // address decode
  logic [5:0] index;
  logic       hit;
  logic       sel_high;
  int         sel_port;
  logic       aligned;
  logic       req_any;
  logic       done;

  assign index   = req.address[IDX_LSB +: 6];
  assign aligned = (req.address[IDX_LSB-1:0] == 2'b00);
  assign req_any = req.read | req.write;
  assign done    = req_any & ack_reg;

  always_comb begin
    hit      = aligned;
    sel_high = 1'b0;
    sel_port = 0;
    case (index)
      IDX_P0_LOW: begin
        sel_port = 0;
      end
      IDX_P0_HIGH: begin
        sel_port = 0;
        sel_high = 1'b1;
      end
      IDX_P1_LOW: begin
        sel_port = 1;
      end
      IDX_P1_HIGH: begin
        sel_port = 1;
        sel_high = 1'b1;
      end
      IDX_P2_LOW: begin
        sel_port = 2;
      end
      IDX_P2_HIGH: begin
        sel_port = 2;
        sel_high = 1'b1;
      end
      IDX_P3_LOW: begin
        sel_port = 3;
      end
      IDX_P3_HIGH: begin
        sel_port = 3;
        sel_high = 1'b1;
      end
      IDX_P4_LOW: begin
        sel_port = 4;
      end
      IDX_P4_HIGH: begin
        sel_port = 4;
        sel_high = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (sel_port >= NUM_PORTS) begin
      hit = 1'b0;
    end
  end

  // one wait cycle per access so read data stands from a flop at the completing edge
  assign avs_waitrequest_out = req_any & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;
  assign avs_response_out    = resp_reg;

  // read value of the addressed register
  logic [7:0] read_byte;
  always_comb begin
    read_byte = READ_IDLE;
    if (hit) begin
      read_byte = sel_high ? drive_high_reg[sel_port] : drive_low_reg[sel_port]; // R11
      if (sel_port == STALE_PORT) begin
        // upper nibble carries no state; it echoes whatever last crossed the bus
        read_byte[STALE_MSB:STALE_LSB] = last_bus_reg[STALE_MSB:STALE_LSB]; // R8
      end
    end
  end

  // bus state next values
  always_comb begin
    ack_next      = req_any & ~ack_reg;
    rdata_next    = rdata_reg;
    resp_next     = resp_reg;
    last_bus_next = last_bus_reg;
    if (req_any & ~ack_reg) begin
      rdata_next = req.read ? {24'h000000, read_byte} : 32'h00000000;
      resp_next  = hit ? RESP_OKAY : RESP_DECODEERR;
    end
    if (done) begin
      // data bus byte of the finished transfer, as the port 4 registers will echo it
      if (req.write && req.byteenable[0]) begin
        last_bus_next = req.writedata[7:0];
      end else if (req.read) begin
        last_bus_next = rdata_reg[7:0];
      end
    end
  end

  // drive register next values
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      drive_low_next[p]  = drive_low_reg[p];
      drive_high_next[p] = drive_high_reg[p];
    end
    // write lands on the edge where waitrequest is low, never earlier
    if (done && req.write && hit && req.byteenable[0]) begin
      if (sel_high) begin
        drive_high_next[sel_port] = req.writedata[7:0]; // R3
      end else begin
        drive_low_next[sel_port] = req.writedata[7:0]; // R2
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h00000000;
      resp_reg     <= RESP_OKAY;
      last_bus_reg <= 8'h00;
      for (int p = 0; p < NUM_PORTS; p++) begin
        drive_low_reg[p]  <= LOW_RESET; // R5
        drive_high_reg[p] <= HIGH_RESET; // R5
      end
    end else begin
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      resp_reg     <= resp_next;
      last_bus_reg <= last_bus_next;
      for (int p = 0; p < NUM_PORTS; p++) begin
        drive_low_reg[p]  <= drive_low_next[p];
        drive_high_reg[p] <= drive_high_next[p];
      end
    end
  end

  // per-pin pad control straight from the stored bits, so a write acts on the next cycle
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      gdm_code_type code;
      logic         value;
      assign code  = gdm_code_type'({drive_high_reg[g / PORT_WIDTH][g % PORT_WIDTH],
                                     drive_low_reg[g / PORT_WIDTH][g % PORT_WIDTH]}); // R1 R10
      assign value = port_output_value_in[g];

      always_comb begin
        pad_ctl_out[g].out      = 1'b0;
        pad_ctl_out[g].oe       = 1'b0;
        pad_ctl_out[g].pull_up  = 1'b0;
        pad_ctl_out[g].input_en = 1'b1;
        case (code)
          DRIVE_RES_HIGH: begin
            pad_ctl_out[g].oe      = ~value; // R4
            pad_ctl_out[g].pull_up = value; // R4
          end
          DRIVE_STRONG: begin
            pad_ctl_out[g].oe  = 1'b1; // R4
            pad_ctl_out[g].out = value; // R4
          end
          DRIVE_HIGHZ: begin
            // input gated off so a floating pad burns no current
            pad_ctl_out[g].input_en = 1'b0; // R5
          end
          DRIVE_OPEN_LOW: begin
            // reading an input here relies on software holding the value bit high
            pad_ctl_out[g].oe = ~value; // R6 R7
          end
          default: begin
            pad_ctl_out[g].input_en = 1'b0;
          end
        endcase
      end

      assign pin_input_out[g] = pin_level_in[g] & pad_ctl_out[g].input_en;

      a_code_map_highz : assert property (@(posedge clk_in) disable iff (reset_in) // R5
        (code == DRIVE_HIGHZ) |-> (!pad_ctl_out[g].oe && !pad_ctl_out[g].pull_up && !pin_input_out[g]))
        else $error("high impedance code drives or passes input");
      a_code_map_open : assert property (@(posedge clk_in) disable iff (reset_in) // R6
        (code == DRIVE_OPEN_LOW) |-> (pad_ctl_out[g].oe == !value && !pad_ctl_out[g].out
                                      && !pad_ctl_out[g].pull_up))
        else $error("open drain code drives wrong level");
      a_code_map_res : assert property (@(posedge clk_in) disable iff (reset_in) // R4
        (code == DRIVE_RES_HIGH) |-> (pad_ctl_out[g].pull_up == value && pad_ctl_out[g].oe == !value))
        else $error("resistive code pad control wrong");
      a_code_map_strong : assert property (@(posedge clk_in) disable iff (reset_in) // R4
        (code == DRIVE_STRONG) |-> (pad_ctl_out[g].oe && pad_ctl_out[g].out == value))
        else $error("strong code pad control wrong");
      a_input_gate : assert property (@(posedge clk_in) disable iff (reset_in) // R5
        pad_ctl_out[g].input_en |-> (pin_input_out[g] == pin_level_in[g]))
        else $error("enabled input does not follow the pin");
    end
  endgenerate

  // checks on the register side
  a_write_then_drive : assert property (@(posedge clk_in) disable iff (reset_in) // R10 R2
    (done && req.write && hit && !sel_high && req.byteenable[0] && sel_port == 0)
      |=> (drive_low_reg[0] == $past(req.writedata[7:0])))
    else $error("low register write not applied next cycle");
  a_write_high_drive : assert property (@(posedge clk_in) disable iff (reset_in) // R3 R10
    (done && req.write && hit && sel_high && req.byteenable[0] && sel_port == 1)
      |=> (drive_high_reg[1] == $past(req.writedata[7:0])))
    else $error("high register write not applied next cycle");
  a_readback_full : assert property (@(posedge clk_in) disable iff (reset_in) // R11
    (req.read && !ack_reg && hit && sel_port < STALE_PORT)
      |=> (avs_readdata_out[7:0] == (sel_high ? drive_high_reg[$past(sel_port)]
                                              : drive_low_reg[$past(sel_port)])))
    else $error("port 0 to 3 readback differs from stored bits");
  a_stale_nibble : assert property (@(posedge clk_in) disable iff (reset_in) // R8
    (req.read && !ack_reg && hit && sel_port == STALE_PORT)
      |=> (avs_readdata_out[7:4] == $past(last_bus_reg[7:4])))
    else $error("port 4 upper nibble not last bus value");
  a_wait_one_cycle : assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(req_any) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("waitrequest not exactly one cycle");
  a_reset_state : assert property (@(posedge clk_in) // R5
    $fell(reset_in) |-> (drive_high_reg[0] == HIGH_RESET && drive_low_reg[0] == LOW_RESET
                         && pad_ctl_out[0].input_en == 1'b0))
    else $error("reset state is not high impedance");
  a_no_write_hold : assert property (@(posedge clk_in) disable iff (reset_in) // R1
    !(done && req.write) |=> (drive_low_reg[0] == $past(drive_low_reg[0])
                              && drive_high_reg[0] == $past(drive_high_reg[0])))
    else $error("drive register changed without a write");

  // masked byte lane: the write still completes but must leave the register alone
  a_masked_write : assert property (@(posedge clk_in) disable iff (reset_in)
    (done && req.write && !req.byteenable[0]) |=> (drive_low_reg[0] == $past(drive_low_reg[0])
                                                  && drive_high_reg[0] == $past(drive_high_reg[0])))
    else $error("masked write changed a drive register");

  // bus answers
  a_unmapped_error : assert property (@(posedge clk_in) disable iff (reset_in)
    (req_any && !ack_reg && !hit)
      |=> (avs_response_out == RESP_DECODEERR && avs_readdata_out == 32'h00000000))
    else $error("unmapped access not refused");
  a_mapped_okay : assert property (@(posedge clk_in) disable iff (reset_in)
    (req_any && !ack_reg && hit) |=> (avs_response_out == RESP_OKAY))
    else $error("mapped access not answered okay");
  a_readdata_upper : assert property (@(posedge clk_in) disable iff (reset_in)
    (req.read && !ack_reg) |=> (avs_readdata_out[31:8] == 24'h000000))
    else $error("read data upper bytes not zero");
  a_response_hold : assert property (@(posedge clk_in) disable iff (reset_in)
    !req_any |=> ($stable(avs_readdata_out) && $stable(avs_response_out)))
    else $error("read answer moved while idle");
  a_reset_outputs : assert property (@(posedge clk_in)
    $fell(reset_in) |-> (avs_readdata_out == 32'h00000000 && avs_response_out == RESP_OKAY))
    else $error("bus answer not cleared by reset");

  // port 4 registers: all eight bits stored, upper nibble of a read echoes the bus
  a_port4_low_nibble : assert property (@(posedge clk_in) disable iff (reset_in) // R8
    (req.read && !ack_reg && hit && !sel_high && sel_port == STALE_PORT)
      |=> (avs_readdata_out[3:0] == drive_low_reg[$past(sel_port)][3:0]))
    else $error("port 4 low nibble not stored bits");
  a_last_bus_write : assert property (@(posedge clk_in) disable iff (reset_in) // R8
    (done && req.write && req.byteenable[0]) |=> (last_bus_reg == $past(req.writedata[7:0])))
    else $error("written byte not kept as last bus value");
  a_port4_write : assert property (@(posedge clk_in) disable iff (reset_in) // R2 R10
    (done && req.write && hit && !sel_high && req.byteenable[0] && sel_port == STALE_PORT)
      |=> (drive_low_reg[$past(sel_port)] == $past(req.writedata[7:0])))
    else $error("port 4 low register write not applied next cycle");

  c_write_low : cover property (@(posedge clk_in) disable iff (reset_in)
    done && req.write && hit && !sel_high);
  c_read_port4 : cover property (@(posedge clk_in) disable iff (reset_in)
    done && req.read && hit && sel_port == STALE_PORT);
  c_unmapped : cover property (@(posedge clk_in) disable iff (reset_in)
    done && !hit);
  c_open_drain : cover property (@(posedge clk_in) disable iff (reset_in)
    drive_high_reg[0][0] && drive_low_reg[0][0]);
  c_write_port4 : cover property (@(posedge clk_in) disable iff (reset_in)
    done && req.write && hit && sel_port == STALE_PORT);

endmodule

`default_nettype wire

// ---- testbench/gdm_pin_model.sv ----
// circuitry outside the port pins: pad drivers, pull-ups and external open-drain pull-downs
`timescale 1ns/100ps
`default_nettype none

module gdm_pin_model
  import gdm_pkg::*;
#(
  parameter int NB = 40
) (
  // clock
  input  wire logic                 clk_in,
  // pad side
  input  wire gdm_pad_type [NB-1:0] pad_ctl_in,
  input  wire logic [NB-1:0]        ext_low_in,
  output logic [NB-1:0]             pin_level_out
);
  // a floating pin flips every cycle so no settled value can pass for a real one
  logic [NB-1:0] float_reg = {(NB/2){2'b01}};

  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      if (pad_ctl_in[i].oe) begin
        pin_level_out[i] = pad_ctl_in[i].out;
      end else if (ext_low_in[i]) begin
        pin_level_out[i] = 1'b0;
      end else if (pad_ctl_in[i].pull_up) begin
        pin_level_out[i] = 1'b1;
      end else begin
        pin_level_out[i] = float_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the gpio drive mode select block
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import gdm_pkg::*;
;
  localparam int NP = NUM_PORTS_DEF;
  localparam int NB = NP * PORT_WIDTH;
  localparam logic [5:0] LO_IDX [NP] = '{IDX_P0_LOW, IDX_P1_LOW, IDX_P2_LOW, IDX_P3_LOW, IDX_P4_LOW};

  logic              clk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic [7:0]        adr = 8'h00;
  logic              rd_en = 1'b0;
  logic              wr_en = 1'b0;
  logic [3:0]        be = 4'h0;
  logic [31:0]       wd = 32'h0;
  logic [31:0]       rdata;
  logic [1:0]        rsp;
  logic              wait_req;
  logic [NB-1:0]     port_val = '0;
  logic [NB-1:0]     ext_low = '0;
  logic [NB-1:0]     pin_level;
  logic [NB-1:0]     pin_in;
  gdm_pad_type [NB-1:0] pad;
  int                n_fail = 0;
  int                samples_checked = 0;
  logic [7:0]        m [NP][2];
  logic [7:0]        last_bus;

  gdm_drive_select #(.NUM_PORTS(NP)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(adr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_byteenable_in(be), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_response_out(rsp), .avs_waitrequest_out(wait_req), .port_output_value_in(port_val),
    .pin_level_in(pin_level), .pin_input_out(pin_in), .pad_ctl_out(pad));

  gdm_pin_model #(.NB(NB)) pins (
    .clk_in(clk_in), .pad_ctl_in(pad), .ext_low_in(ext_low), .pin_level_out(pin_level));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] addr(input int p, input int h);
    return {LO_IDX[p] + 6'(h), 2'b00};
  endfunction

  // one access: hold the request until waitrequest is sampled low, take the answer at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] b, input logic [7:0] d,
                      output logic [31:0] r, output logic [1:0] s);
    int n;
    @(posedge clk_in);
    adr <= a;
    rd_en <= !wr;
    wr_en <= wr;
    be <= b;
    wd <= {24'h0, d};
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (wait_req === 1'b0) break;
    end
    if (n == 16) begin
      n_fail++;
      end_sim();
    end else begin
      r = rdata;
      s = rsp;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
    end
  endtask

  task automatic reg_wr(input int p, input int h, input logic [7:0] d, input logic [3:0] b);
    logic [31:0] r;
    logic [1:0]  s;
    xfer(1'b1, addr(p, h), b, d, r, s);
    chk("write response", {30'h0, s}, {30'h0, RESP_OKAY});
    if (b[0]) begin
      m[p][h] = d;
      last_bus = d;
    end
  endtask

  task automatic reg_rd(input int p, input int h);
    logic [31:0] r;
    logic [1:0]  s;
    logic [7:0]  e;
    e = m[p][h];
    if (p == STALE_PORT) e[7:4] = last_bus[7:4];
    xfer(1'b0, addr(p, h), 4'h1, 8'h00, r, s);
    chk("read data", r, {24'h0, e});
    if (p == STALE_PORT) chk("masked drive bits", {28'h0, r[3:0]}, {28'h0, m[p][h][3:0]});
    chk("read response", {30'h0, s}, {30'h0, RESP_OKAY});
    last_bus = e;
  endtask

  // unmapped or misaligned read: zero data and a decode error
  task automatic bad_rd(input logic [7:0] a);
    logic [31:0] r;
    logic [1:0]  s;
    xfer(1'b0, a, 4'h1, 8'h00, r, s);
    chk("unmapped data", r, 32'h0);
    chk("unmapped response", {30'h0, s}, {30'h0, RESP_DECODEERR});
    last_bus = 8'h00;
  endtask

  // refused write: decode error, nothing stored, its byte still echoed by port 4
  task automatic bad_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic [1:0]  s;
    xfer(1'b1, a, 4'h1, d, r, s);
    chk("unmapped write response", {30'h0, s}, {30'h0, RESP_DECODEERR});
    last_bus = d;
  endtask

  task automatic rd_all;
    for (int p = 0; p < NP; p++) begin
      for (int h = 0; h < 2; h++) begin
        reg_rd(p, h);
      end
    end
  endtask

  // expected pad control per pin; out is only meaningful while the pad drives
  task automatic chk_pads;
    logic [1:0] c;
    logic [3:0] e;
    @(negedge clk_in);
    for (int i = 0; i < NB; i++) begin
      c = {m[i/8][1][i%8], m[i/8][0][i%8]};
      e[0] = (c != 2'b10);
      e[1] = (c == 2'b00) && port_val[i];
      e[2] = (c == 2'b01) || (c != 2'b10 && !port_val[i]);
      e[3] = e[2] && (c == 2'b01) && port_val[i];
      chk("pad control", {28'h0, pad[i].out & e[2], pad[i].oe, pad[i].pull_up, pad[i].input_en}, {28'h0, e});
      chk("pin input", {31'h0, pin_in[i]}, {31'h0, e[0] & pin_level[i]});
    end
  endtask

  task automatic reset_dut;
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int p = 0; p < NP; p++) begin
      m[p][0] = LOW_RESET;
      m[p][1] = HIGH_RESET;
    end
    last_bus = 8'h00;
  endtask

  task automatic wr_all(input logic rnd, input logic [7:0] lo, input logic [7:0] hi);
    for (int p = 0; p < NP; p++) begin
      for (int h = 0; h < 2; h++) begin
        reg_wr(p, h, rnd ? 8'($urandom) : (h ? hi : lo), 4'h1);
        chk_pads();
      end
    end
  endtask

  initial begin
    void'($urandom(32'hd0e0));
    reset_dut();
    port_val <= NB'({$urandom, $urandom});
    ext_low <= NB'({$urandom, $urandom});
    rd_all();
    chk_pads();
    // every pin code appears on each port
    wr_all(1'b0, 8'h55, 8'h33);
    rd_all();
    repeat (5) begin
      port_val <= NB'({$urandom, $urandom});
      ext_low <= NB'({$urandom, $urandom});
      wr_all(1'b1, 8'h00, 8'h00);
      rd_all();
    end
    // refused writes leave the registers alone
    reg_wr(0, 0, 8'($urandom), 4'he);
    bad_wr(addr(1, 0) | 8'h01, 8'hc3);
    rd_all();
    bad_rd(8'h08);
    reg_rd(4, 1);
    bad_rd(addr(1, 0) | 8'h02);
    reg_wr(4, 0, 8'($urandom), 4'h1);
    bad_rd(8'h48);
    reg_rd(4, 0);
    // open-drain input use keeps the output value high
    port_val <= '1;
    wr_all(1'b0, 8'hff, 8'hff);
    ext_low <= NB'({$urandom, $urandom});
    chk_pads();
    reset_dut();
    rd_all();
    chk_pads();
    end_sim();
  end
endmodule
`default_nettype wire
